// file: logic/cedma_pkg.sv
// crypto engine dma control: register map, field positions, descriptor
// layout, engine states and the carrier structs shared by the design.
// assumes a 32-bit wishbone register bus and a 32-bit memory port.
package cedma_pkg;

  localparam int unsigned CEDMA_DW = 32;
  localparam int unsigned CEDMA_AW = 4;

  // register byte offsets
  localparam logic [3:0] CEDMA_ADR_CTRL = 4'h0;
  localparam logic [3:0] CEDMA_ADR_BASE = 4'h4;
  localparam logic [3:0] CEDMA_ADR_STAT = 4'h8;

  // control field positions
  localparam int unsigned CEDMA_B_OSWAP = 7;
  localparam int unsigned CEDMA_B_ENGINE_SOFT_RESET = 6;
  localparam int unsigned CEDMA_B_ISWAP = 5;
  localparam int unsigned CEDMA_B_FETCH = 2;
  localparam int unsigned CEDMA_B_POLL = 1;
  localparam int unsigned CEDMA_B_DMA = 0;

  // status field positions
  localparam int unsigned CEDMA_S_KICK = 8;
  localparam int unsigned CEDMA_S_CNT = 16;

  // descriptor: word0 {valid, len}, word1 src, word2 dst, word3 next
  localparam int unsigned CEDMA_D_VALID = 31;
  localparam int unsigned CEDMA_LEN_W = 16;
  localparam logic [1:0] CEDMA_D_LAST = 2'h3;
  localparam logic [31:0] CEDMA_STEP = 32'h4;
  localparam logic [7:0] CEDMA_POLL_CYCLES = 8'h10;

  typedef enum logic [4:0] {
    CEDMA_IDLE = 5'h01,
    CEDMA_FETCH = 5'h02,
    CEDMA_MOVE = 5'h04,
    CEDMA_CLOSE = 5'h08,
    CEDMA_WAIT = 5'h10
  } cedma_state_type;

  typedef struct packed {
    logic oswap;
    logic engine_soft_reset;
    logic iswap;
    logic fetch_en;
    logic poll_en;
    logic dma_en;
  } cedma_ctrl_type;

  localparam cedma_ctrl_type CEDMA_CTRL_RST = '0;

  typedef struct packed {
    logic req;
    logic we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } cedma_mreq_type;

  // byte order reversal of one word
  function automatic logic [31:0] cedma_swap(input logic [31:0] w,
                                             input logic en);
    cedma_swap = en ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction : cedma_swap

endpackage : cedma_pkg

// file: logic/cedma_ctrl.sv
// crypto engine dma control: fifo and top with wishbone slave, descriptor
// walker and the byte swapping data path.
// assumes a memory slave that holds rdata valid with a one-cycle ack.
//
// The address map and the Wishbone slave port were decided locally.
`timescale 1ns/100ps

module cedma_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } cedma_fifo_state_type;

  cedma_fifo_state_type s;
  cedma_fifo_state_type next_s;
  logic push;
  logic pop;

  // depth must be a power of two so the pointers wrap on their own
  assign in_ready_o = (s.cnt != FULL);
  assign out_valid_o = (s.cnt != '0);
  assign out_data_o = s.mem[s.rp];
  assign count_o = s.cnt;
  assign push = in_valid_i & in_ready_o;
  assign pop = out_ready_i & out_valid_o;

  // pointer and level update, flush wins over traffic
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data_i;
      next_s.wp = AW'(s.wp + 1'b1);
    end
    if (pop) begin
      next_s.rp = AW'(s.rp + 1'b1);
    end
    case ({push, pop})
      2'b10: next_s.cnt = (AW+1)'(s.cnt + 1'b1);
      2'b01: next_s.cnt = (AW+1)'(s.cnt - 1'b1);
      default: next_s.cnt = s.cnt;
    endcase
    if (flush_i) begin
      next_s.wp = '0;
      next_s.rp = '0;
      next_s.cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= next_s;
    end
  end

endmodule : cedma_fifo

// Function
// - output swap set reverses bytes of every data word the dma writes; the descriptor write-back is not swapped.
// - input swap set reverses bytes of every data word the dma reads; descriptor words are read unswapped.
// - writing one starts engine reset; hardware clears the bit itself.
// - descriptors are fetched only while fetch enable is one.
// - with poll enable, re-read the descriptor until valid; else no poll.
// - the dma moves nothing while its enable is zero.
// - control fields reset to zero; unused bits read zero.
module cedma_ctrl
  import cedma_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16,
  parameter logic [7:0] POLL_CYCLES = cedma_pkg::CEDMA_POLL_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cedma_pkg::CEDMA_AW-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [cedma_pkg::CEDMA_DW-1:0] wb_dat_i,
  output logic [cedma_pkg::CEDMA_DW-1:0] wb_dat_o,
  output logic wb_ack_o,
  output cedma_pkg::cedma_mreq_type mem_o,
  input wire logic mem_ack_i,
  input wire logic [cedma_pkg::CEDMA_DW-1:0] mem_rdata_i,
  output logic engine_soft_reset_o
);
  import cedma_pkg::*;

  localparam int unsigned CW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    cedma_state_type st;
    cedma_ctrl_type ctrl;
    logic [31:0] base;
    logic [31:0] cur;
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] nxt;
    logic [CEDMA_LEN_W-1:0] len;
    logic [CEDMA_LEN_W-1:0] rd_left;
    logic [CEDMA_LEN_W-1:0] wr_left;
    logic [1:0] widx;
    logic [7:0] wait_cnt;
    logic kick;
    cedma_mreq_type mem;
    logic ack;
    logic [31:0] dat;
  } cedma_regs_type;

  cedma_regs_type r;
  cedma_regs_type next_r;
  logic wb_take;
  logic mem_done;
  logic fifo_push;
  logic fifo_pop;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [31:0] fifo_in;
  logic [31:0] fifo_out;
  logic [CW-1:0] fifo_cnt;

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign mem_o = r.mem;
  assign engine_soft_reset_o = r.ctrl.engine_soft_reset;

  // data buffer between memory reads and memory writes
  cedma_fifo #(
    .WIDTH(CEDMA_DW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .flush_i(r.ctrl.engine_soft_reset),
    .in_valid_i(fifo_push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(fifo_in),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(fifo_pop),
    .out_data_o(fifo_out),
    .count_o(fifo_cnt)
  );

  assign wb_take = wb_cyc_i & wb_stb_i & ~r.ack;
  assign mem_done = r.mem.req & mem_ack_i;
  // read data enters the buffer in the ack cycle
  assign fifo_push = mem_done & ~r.mem.we & (r.st == CEDMA_MOVE)
                     & ~r.ctrl.engine_soft_reset;
  assign fifo_in = cedma_swap(mem_rdata_i, r.ctrl.iswap);

  // bus slave, descriptor walker and request issue
  always_comb begin
    next_r = r;
    fifo_pop = 1'b0;
    next_r.ack = wb_take;
    // a new request waits one cycle after an answer, so the buffer
    // level seen at issue already holds the last read word
    if (mem_done) begin
      next_r.mem.req = 1'b0;
    end
    case (r.st)
      CEDMA_IDLE: begin
        if (r.kick && r.ctrl.fetch_en) begin
          next_r.st = CEDMA_FETCH;
          next_r.widx = '0;
          next_r.kick = 1'b0;
        end
      end
      CEDMA_FETCH: begin
        if (mem_done) begin
          next_r.widx = 2'(r.widx + 1'b1);
          case (r.widx)
            2'h0: begin
              next_r.len = mem_rdata_i[CEDMA_LEN_W-1:0];
              next_r.rd_left = mem_rdata_i[CEDMA_LEN_W-1:0];
              next_r.wr_left = mem_rdata_i[CEDMA_LEN_W-1:0];
              if (!mem_rdata_i[CEDMA_D_VALID]) begin
                next_r.widx = '0;
                next_r.wait_cnt = POLL_CYCLES;
                next_r.st = r.ctrl.poll_en ? CEDMA_WAIT : CEDMA_IDLE;
              end
            end
            2'h1: next_r.src = mem_rdata_i;
            2'h2: next_r.dst = mem_rdata_i;
            default: begin
              next_r.nxt = mem_rdata_i;
              next_r.st = (r.len == '0) ? CEDMA_CLOSE : CEDMA_MOVE;
            end
          endcase
        end
      end
      CEDMA_MOVE: begin
        if (mem_done && !r.mem.we) begin
          next_r.rd_left = CEDMA_LEN_W'(r.rd_left - 1'b1);
          next_r.src = r.src + CEDMA_STEP;
        end
        if (mem_done && r.mem.we) begin
          next_r.wr_left = CEDMA_LEN_W'(r.wr_left - 1'b1);
          next_r.dst = r.dst + CEDMA_STEP;
          if (r.wr_left == CEDMA_LEN_W'(1)) begin
            next_r.st = CEDMA_CLOSE;
          end
        end
      end
      CEDMA_CLOSE: begin
        if (mem_done) begin
          next_r.cur = r.nxt;
          next_r.widx = '0;
          next_r.st = r.ctrl.fetch_en ? CEDMA_FETCH : CEDMA_IDLE;
        end
      end
      CEDMA_WAIT: begin
        if (!r.ctrl.poll_en || !r.ctrl.fetch_en) begin
          next_r.st = CEDMA_IDLE;
        end else if (r.wait_cnt == '0) begin
          next_r.st = CEDMA_FETCH;
        end else begin
          next_r.wait_cnt = 8'(r.wait_cnt - 1'b1);
        end
      end
      default: next_r.st = CEDMA_IDLE;
    endcase
    // issue: nothing reaches memory while the dma is disabled
    if (!r.mem.req && r.ctrl.dma_en && !r.ctrl.engine_soft_reset) begin
      case (r.st)
        CEDMA_FETCH: begin
          if (r.ctrl.fetch_en) begin
            next_r.mem.req = 1'b1;
            next_r.mem.we = 1'b0;
            next_r.mem.addr = r.cur + {28'h0, r.widx, 2'h0};
          end
        end
        CEDMA_MOVE: begin
          if (fifo_out_valid && (r.rd_left == '0 || !fifo_in_ready)) begin
            fifo_pop = 1'b1;
            next_r.mem.req = 1'b1;
            next_r.mem.we = 1'b1;
            next_r.mem.addr = r.dst;
            next_r.mem.wdata = cedma_swap(fifo_out, r.ctrl.oswap);
          end else if (r.rd_left != '0 && fifo_in_ready) begin
            next_r.mem.req = 1'b1;
            next_r.mem.we = 1'b0;
            next_r.mem.addr = r.src;
          end
        end
        CEDMA_CLOSE: begin
          // hand the descriptor back with its valid bit cleared
          next_r.mem.req = 1'b1;
          next_r.mem.we = 1'b1;
          next_r.mem.addr = r.cur;
          next_r.mem.wdata = {16'h0, r.len};
        end
        default: ;
      endcase
    end
    // engine reset drops everything in flight, hardware clears the bit
    if (r.ctrl.engine_soft_reset) begin
      next_r.st = CEDMA_IDLE;
      next_r.mem.req = 1'b0;
      next_r.kick = 1'b0;
      next_r.widx = '0;
      next_r.rd_left = '0;
      next_r.wr_left = '0;
      next_r.cur = r.base;
      next_r.ctrl.engine_soft_reset = 1'b0;
    end
    // register writes come last so a set beats the hardware clear
    if (wb_take && wb_we_i) begin
      if (wb_adr_i == CEDMA_ADR_CTRL && wb_sel_i[0]) begin
        next_r.ctrl.oswap = wb_dat_i[CEDMA_B_OSWAP];
        next_r.ctrl.iswap = wb_dat_i[CEDMA_B_ISWAP];
        next_r.ctrl.fetch_en = wb_dat_i[CEDMA_B_FETCH];
        next_r.ctrl.poll_en = wb_dat_i[CEDMA_B_POLL];
        next_r.ctrl.dma_en = wb_dat_i[CEDMA_B_DMA];
        next_r.kick = wb_dat_i[CEDMA_B_FETCH];
        if (wb_dat_i[CEDMA_B_ENGINE_SOFT_RESET]) begin
          next_r.ctrl.engine_soft_reset = 1'b1;
        end
      end
      if (wb_adr_i == CEDMA_ADR_BASE) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            next_r.base[8*b +: 8] = wb_dat_i[8*b +: 8];
          end
        end
        // a running walk keeps its pointer
        if (r.st == CEDMA_IDLE) begin
          next_r.cur = next_r.base;
        end
      end
    end
    // read mux, unused bits and unmapped offsets read zero
    if (wb_take) begin
      next_r.dat = '0;
      case (wb_adr_i)
        CEDMA_ADR_CTRL: begin
          next_r.dat[CEDMA_B_OSWAP] = r.ctrl.oswap;
          next_r.dat[CEDMA_B_ENGINE_SOFT_RESET] = r.ctrl.engine_soft_reset;
          next_r.dat[CEDMA_B_ISWAP] = r.ctrl.iswap;
          next_r.dat[CEDMA_B_FETCH] = r.ctrl.fetch_en;
          next_r.dat[CEDMA_B_POLL] = r.ctrl.poll_en;
          next_r.dat[CEDMA_B_DMA] = r.ctrl.dma_en;
        end
        CEDMA_ADR_BASE: next_r.dat = r.base;
        CEDMA_ADR_STAT: begin
          next_r.dat[4:0] = r.st;
          next_r.dat[CEDMA_S_KICK] = r.kick;
          next_r.dat[CEDMA_S_CNT +: CW] = fifo_cnt;
        end
        default: next_r.dat = '0;
      endcase
    end
  end

  // the clock enable freezes every bit of state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r <= '0;
      r.st <= CEDMA_IDLE;
      r.ctrl <= CEDMA_CTRL_RST;
    end else if (ce_i) begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  out_swap_a: assert property (ce_i && fifo_pop |=> mem_o.wdata ==
    ($past(r.ctrl.oswap) ? {$past(fifo_out[7:0]), $past(fifo_out[15:8]),
    $past(fifo_out[23:16]), $past(fifo_out[31:24])} : $past(fifo_out)))
    else $error("output word not swapped as set");
  // checked at the buffer output, so a broken swap path is caught too
  in_swap_a: assert property (ce_i && fifo_push && fifo_cnt == '0
    |=> fifo_out == ($past(r.ctrl.iswap) ? {$past(mem_rdata_i[7:0]),
    $past(mem_rdata_i[15:8]), $past(mem_rdata_i[23:16]),
    $past(mem_rdata_i[31:24])} : $past(mem_rdata_i)))
    else $error("input word not swapped as set");
  reset_clear_a: assert property (ce_i && r.ctrl.engine_soft_reset && !wb_take
    |=> !r.ctrl.engine_soft_reset)
    else $error("engine reset bit not cleared");
  fetch_gate_a: assert property (mem_o.req && !$past(mem_o.req)
    && r.st == CEDMA_FETCH |-> $past(r.ctrl.fetch_en))
    else $error("descriptor fetched while fetch disabled");
  poll_gate_a: assert property (r.st == CEDMA_WAIT
    && $past(r.st) != CEDMA_WAIT |-> $past(r.ctrl.poll_en))
    else $error("poll wait entered without poll enable");
  dma_gate_a: assert property ($rose(mem_o.req) |->
    $past(r.ctrl.dma_en))
    else $error("memory request while dma disabled");
  unused_zero_a: assert property (wb_ack_o && !wb_we_i
    && wb_adr_i == CEDMA_ADR_CTRL |-> wb_dat_o[31:8] == '0
    && wb_dat_o[4:3] == '0)
    else $error("unused control bits read nonzero");
  abort_a: assert property (ce_i && r.ctrl.engine_soft_reset |=> !mem_o.req
    && r.st == CEDMA_IDLE && fifo_cnt == '0)
    else $error("engine reset left work in flight");
  ctrl_reset_a: assert property ($past(rst_i) |->
    r.ctrl == CEDMA_CTRL_RST)
    else $error("control not zero after reset");

  close_c: cover property (r.st == CEDMA_CLOSE && mem_done);
  poll_c: cover property (r.st == CEDMA_WAIT ##1 r.st == CEDMA_FETCH);
  full_c: cover property (!fifo_in_ready && r.st == CEDMA_MOVE);
  engine_soft_reset_c: cover property (r.ctrl.engine_soft_reset && r.st == CEDMA_MOVE);

endmodule : cedma_ctrl

// file: tb/cedma_mem.sv
// memory model for the crypto dma: word array with a settable answer delay.
// assumes one outstanding request, held by the block until it sees the ack.
`timescale 1ns/100ps
module cedma_mem
  import cedma_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire cedma_pkg::cedma_mreq_type mem_i,
  input wire logic [3:0] lat_i,
  output logic ack_o,
  output logic [31:0] rdata_o
);
  logic [31:0] ram [0:127];
  logic [3:0] wait_cnt;
  int unsigned n_req;

  // answer after lat_i waiting cycles; read data is scrambled whenever it
  // is not valid, so a block sampling it late sees garbage, not the word
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      wait_cnt <= 4'h0;
      n_req <= 0;
      rdata_o <= 32'h5a5a_a5a5;
    end else if (!ack_o && mem_i.req && wait_cnt >= lat_i) begin
      ack_o <= 1'b1;
      wait_cnt <= 4'h0;
      n_req <= n_req + 1;
      rdata_o <= mem_i.we ? ~rdata_o : ram[mem_i.addr[8:2]];
      if (mem_i.we) begin
        ram[mem_i.addr[8:2]] <= mem_i.wdata;
      end
    end else begin
      ack_o <= 1'b0;
      wait_cnt <= (mem_i.req && !ack_o) ? wait_cnt + 4'h1 : 4'h0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : cedma_mem

// file: tb/cedma_ctrl_tb.sv
// testbench for the crypto dma control: registers over wishbone, swapped
// transfers, polling, enables and engine reset against a memory model.
// assumes the short poll count set below; memory is preloaded directly.
`timescale 1ns/100ps
module cedma_ctrl_tb;
  import cedma_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic req = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [3:0] lat = 4'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rd;
  logic [31:0] exp_w;
  logic [31:0] wb_dat;
  logic [31:0] mrd;
  logic wb_ack;
  logic mack;
  logic srst;
  cedma_mreq_type mreq;
  int err_total = 0;
  int num_checks = 0;
  int pulses = 0;
  int n0;

  always #4 clk_i = ~clk_i;

  cedma_ctrl #(.FIFO_DEPTH(16), .POLL_CYCLES(8'h04)) i_cedma_ctrl (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat), .wb_ack_o(wb_ack), .mem_o(mreq),
    .mem_ack_i(mack), .mem_rdata_i(mrd), .engine_soft_reset_o(srst));

  cedma_mem i_cedma_mem (.clk_i(clk_i), .rst_i(rst_i), .mem_i(mreq),
    .lat_i(lat), .ack_o(mack), .rdata_o(mrd));

  // count engine reset pulses seen at the port
  always @(posedge clk_i) begin
    if (srst === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [31:0] g, input logic [31:0] e,
                     input string m);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %0t %s got %h want %h", $time, m, g, e);
    end
  endtask : chk

  // one classic cycle; request held until the edge that samples ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 20);
    rd = wb_dat;
    req <= 1'b0;
    we <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1, "no ack");
  endtask : wb

  task automatic rchk(input logic [3:0] a, input logic [31:0] e,
                      input string m);
    wb(1'b0, a, 32'h0);
    chk(rd, e, m);
  endtask : rchk

  // engine reset first so the walk restarts at the base address
  // callers write the descriptors before this enables fetch
  task automatic kick(input logic [7:0] c);
    wb(1'b1, CEDMA_ADR_CTRL, 32'h40);
    wb(1'b1, CEDMA_ADR_CTRL, {24'h0, c});
  endtask : kick

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      wb(1'b0, CEDMA_ADR_STAT, 32'h0);
      n++;
    end while (rd[8:0] !== 9'h001 && n < 400);
    chk({23'h0, rd[8:0]}, 32'h1, "engine idle");
  endtask : wait_idle

  function automatic logic [31:0] rev(input logic [31:0] w);
    rev = {w[7:0], w[15:8], w[23:16], w[31:24]};
  endfunction : rev

  function automatic logic [31:0] srcw(input int i);
    srcw = 32'h0102_0304 + 32'h1010_1010 * i;
  endfunction : srcw

  // descriptor at 0x40: src 0x80, dst 0xc0, next 0x100 (left invalid)
  task automatic setd(input logic [31:0] w0, input int n);
    i_cedma_mem.ram[16] = w0;
    i_cedma_mem.ram[17] = 32'h80;
    i_cedma_mem.ram[18] = 32'hc0;
    i_cedma_mem.ram[19] = 32'h100;
    i_cedma_mem.ram[64] = 32'h0;
    for (int i = 0; i < n; i++) begin
      i_cedma_mem.ram[32 + i] = srcw(i);
      i_cedma_mem.ram[48 + i] = 32'h0;
    end
  endtask : setd

  // watchdog sized well beyond the expected run length
  initial begin
    #480000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    wrap_up();
  end

  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rchk(CEDMA_ADR_CTRL, 32'h0, "ctrl reset");
    rchk(CEDMA_ADR_STAT, 32'h1, "status reset");
    wb(1'b1, CEDMA_ADR_CTRL, 32'hffff_ffd8);
    rchk(CEDMA_ADR_CTRL, 32'h80, "unused bits and self clear");
    chk(pulses, 1, "reset pulse");
    rchk(4'hc, 32'h0, "unmapped reads zero");
    // control lives in byte lane 0 only; a write without it is ignored
    sel <= 4'he;
    wb(1'b1, CEDMA_ADR_CTRL, 32'h01);
    sel <= 4'hf;
    rchk(CEDMA_ADR_CTRL, 32'h80, "ctrl needs lane 0");
    $display("test registers done");
    // either enable alone must not put a request on memory
    setd(32'h8000_0002, 2);
    wb(1'b1, CEDMA_ADR_BASE, 32'h40);
    n0 = i_cedma_mem.n_req;
    kick(8'h04);
    repeat (40) @(posedge clk_i);
    chk(i_cedma_mem.n_req, n0, "fetch without dma");
    kick(8'h01);
    repeat (40) @(posedge clk_i);
    chk(i_cedma_mem.n_req, n0, "dma without fetch");
    $display("test enables done");
    // all four swap modes, memory answering ever slower
    for (int m = 0; m < 4; m++) begin
      setd(32'h8000_0000 | (m + 1), m + 1);
      lat <= m[3:0];
      kick({m[1], 1'b0, m[0], 5'h05});
      wait_idle();
      for (int i = 0; i <= m; i++) begin
        exp_w = m[0] ? rev(srcw(i)) : srcw(i);
        exp_w = m[1] ? rev(exp_w) : exp_w;
        chk(i_cedma_mem.ram[48 + i], exp_w, "dst word");
      end
      chk(i_cedma_mem.ram[16], m + 1, "closed descriptor");
      n0 = i_cedma_mem.n_req;
      repeat (40) @(posedge clk_i);
      chk(i_cedma_mem.n_req, n0, "no poll when off");
    end
    $display("test swaps done");
    // invalid descriptor is reread until software validates it
    setd(32'h0000_0002, 2);
    lat <= 4'h0;
    n0 = i_cedma_mem.n_req;
    kick(8'h07);
    repeat (80) @(posedge clk_i);
    chk(i_cedma_mem.n_req - n0 > 8, 1, "descriptor reread");
    i_cedma_mem.ram[16] = 32'h8000_0002;
    // with poll on, the walk keeps polling the next descriptor, so wait
    // for the closed descriptor instead of for idle
    n0 = 0;
    while (i_cedma_mem.ram[16] !== 32'h2 && n0 < 400) begin
      @(posedge clk_i);
      n0++;
    end
    chk(i_cedma_mem.ram[16], 32'h2, "polled descriptor closed");
    chk(i_cedma_mem.ram[48], srcw(0), "polled transfer");
    chk(i_cedma_mem.ram[49], srcw(1), "polled transfer");
    $display("test polling done");
    // engine reset in mid transfer abandons it
    setd(32'h8000_000c, 12);
    lat <= 4'h5;
    kick(8'h05);
    // long enough to finish the descriptor and be moving data
    repeat (60) @(posedge clk_i);
    wb(1'b1, CEDMA_ADR_CTRL, 32'h41);
    repeat (2) @(posedge clk_i);
    #1;
    chk(mreq.req, 1'b0, "request dropped");
    n0 = i_cedma_mem.n_req;
    rchk(CEDMA_ADR_STAT, 32'h1, "idle after reset");
    rchk(CEDMA_ADR_CTRL, 32'h1, "reset bit cleared");
    repeat (30) @(posedge clk_i);
    chk(i_cedma_mem.n_req, n0, "no traffic after reset");
    chk(pulses, 10, "reset pulse count");
    $display("test engine reset done");
    wrap_up();
  end
endmodule : cedma_ctrl_tb
